/* File: pif_map.svh */
// Opcodes, field codes, register offsets and reset values of the interrupt and error-flag unit
// What this block does
// [RULE1] Clear-flags type 0 clears all flags
// [RULE2] Clear-flags types 1 to 5 clear one flag
// [RULE3] Enable-interrupt sets the numbered interrupt enable
// [RULE4] Enable number 255 turns global processing on
// [RULE5] Disable-interrupt clears the numbered interrupt enable
// [RULE6] Disable number 255 turns global processing off
// [RULE7] Bank and value ignored for these three
// [RULE8] Define-vector stores handler address per interrupt
// [RULE9] Later define-vector overwrites the stored address
// [RULE10] Return ends handler and resumes program
// [RULE11] Return restores accumulator, X, flags, counter
// [RULE12] Program ends handlers with return, never falls in
// [RULE13] Vector and return used only in standalone; the code also accepts both from direct mode
// [RULE14] Taken interrupt saves context, jumps to vector
// [RULE15] Checksum is byte sum; direct replies 100
`ifndef PIF_MAP_SVH
`define PIF_MAP_SVH

`define PIF_OP_EI 8'h19
`define PIF_OP_DI 8'h1a
`define PIF_OP_CLE 8'h24
`define PIF_OP_DEFINE_VECTOR_OP 8'h25
`define PIF_OP_RETURN_FROM_HANDLER_OP 8'h26

`define PIF_IRQ_GLOBAL 8'hff
`define PIF_CLE_ALL 8'h00
`define PIF_NFLAG 5

`define PIF_ST_OK 8'h64
`define PIF_ST_CHK 8'h01

`define PIF_REG_STAT 8'h00
`define PIF_REG_MASK 8'h04
`define PIF_REG_ERR 8'h08
`define PIF_REG_EN 8'h0c
`define PIF_REG_PEND 8'h10
`define PIF_REG_CTRL 8'h14
`define PIF_REG_STATE 8'h18

`define PIF_NEV 4
`define PIF_EV_ENTRY 0
`define PIF_EV_RETURN 1
`define PIF_EV_ERROR 2
`define PIF_EV_CHK 3
`define PIF_MASK_RST 4'h0
`define PIF_CTRL_RST 1'b0

`endif

/* File: pif_pkg.sv */
// Types shared by the interrupt and error-flag unit
package pif_pkg;

    typedef enum logic [0:0] {
        pif_run = 1'b0,
        pif_handler = 1'b1
    } pif_mode_t;

    typedef enum logic [2:0] {
        pif_nop = 3'b000,
        pif_cle = 3'b001,
        pif_ei = 3'b010,
        pif_di = 3'b011,
        pif_define_vector_op = 3'b100,
        pif_return_from_handler_op = 3'b101
    } pif_op_t;

endpackage

/* File: pif_vec_if.sv */
// Write and lookup port of the handler address table
`timescale 1ns/1ps

interface pif_vec_if #(
    parameter int NUM_IRQ = 16,
    parameter int VEC_W = 16
);
    localparam int IDX_W = $clog2(NUM_IRQ);
    logic wr_en;
    logic [IDX_W-1:0] wr_idx;
    logic [VEC_W-1:0] wr_addr;
    logic [IDX_W-1:0] rd_idx;
    logic [VEC_W-1:0] rd_addr;

    modport user_side (output wr_en, output wr_idx, output wr_addr, output rd_idx,
        input rd_addr);
    modport table_side (input wr_en, input wr_idx, input wr_addr, input rd_idx,
        output rd_addr);
endinterface

/* File: pif_vector_table.sv */
// Handler entry address per interrupt number
`timescale 1ns/1ps

module pif_vector_table #(
    parameter int NUM_IRQ = 16,
    parameter int VEC_W = 16
) (
    input logic clock,
    input logic rst_b,
    input logic clk_en,
    pif_vec_if.table_side vec
);

    logic [VEC_W-1:0] entry [NUM_IRQ];

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            for (int i = 0; i < NUM_IRQ; i++) begin
                entry[i] <= '0;
            end
        end else if (clk_en && vec.wr_en) begin
            // Plain overwrite, so a vector can be redefined at any time
            entry[vec.wr_idx] <= vec.wr_addr; // [RULE8] [RULE9]
        end
    end

    assign vec.rd_addr = entry[vec.rd_idx];

endmodule // pif_vector_table

/* File: pif_core.sv */
// Interrupt and error-flag instruction unit of the stepper command interpreter
`timescale 1ns/1ps
`include "pif_map.svh"

module pif_core #(
    parameter int NUM_IRQ = 16,
    parameter int VEC_W = 16,
    parameter int PC_W = 16
) (
    input logic clock,
    input logic rst_b,
    input logic clk_en,
    input logic instr_valid,
    input logic instr_direct,
    input logic [7:0] instr_target,
    input logic [7:0] instr_opcode,
    input logic [7:0] instr_type,
    input logic [7:0] instr_bank,
    input logic [31:0] instr_value,
    input logic [7:0] instr_checksum,
    output logic reply_valid,
    output logic [7:0] reply_status,
    output logic [7:0] reply_opcode,
    input logic [`PIF_NFLAG-1:0] err_event,
    output logic [`PIF_NFLAG-1:0] err_flags,
    input logic [NUM_IRQ-1:0] irq_src,
    input logic [31:0] cpu_accu,
    input logic [31:0] cpu_x,
    input logic [7:0] cpu_flags,
    input logic [PC_W-1:0] cpu_pc,
    output logic handler_jump,
    output logic [VEC_W-1:0] jump_addr,
    output logic restore_valid,
    output logic [31:0] restore_accu,
    output logic [31:0] restore_x,
    output logic [7:0] restore_flags,
    output logic [PC_W-1:0] restore_pc,
    output logic in_handler,
    input logic [7:0] reg_addr,
    input logic [31:0] reg_wdata,
    input logic reg_wr,
    input logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq
);

    localparam int IDX_W = $clog2(NUM_IRQ);
    localparam logic [7:0] IRQ_LIM = 8'(NUM_IRQ);

    // Instruction decode

    logic [7:0] sum;
    logic sum_ok;
    logic accept;
    logic type_ok;
    pif_pkg::pif_op_t op;

    // Bank byte takes part in the checksum only
    always_comb begin
        sum = instr_target + instr_opcode + instr_type + instr_bank
            + instr_value[31:24] + instr_value[23:16]
            + instr_value[15:8] + instr_value[7:0];
    end

    assign sum_ok = (sum == instr_checksum); // [RULE15]

    // Stored program lines carry no checksum worth checking
    assign accept = instr_valid && (!instr_direct || sum_ok); // [RULE15]

    // Number 255 never passes this test, so the global enable can not
    // alias onto a single interrupt enable for any legal NUM_IRQ
    assign type_ok = (instr_type < IRQ_LIM);

    always_comb begin
        op = pif_pkg::pif_nop;
        if (accept) begin
            case (instr_opcode)
                `PIF_OP_CLE: op = pif_pkg::pif_cle;
                `PIF_OP_EI: op = pif_pkg::pif_ei; // [RULE3]
                `PIF_OP_DI: op = pif_pkg::pif_di; // [RULE5]
                `PIF_OP_DEFINE_VECTOR_OP: op = pif_pkg::pif_define_vector_op;
                `PIF_OP_RETURN_FROM_HANDLER_OP: op = pif_pkg::pif_return_from_handler_op; // [RULE10]
                default: op = pif_pkg::pif_nop;
            endcase
        end
    end

    // Error flags

    logic [`PIF_NFLAG-1:0] err_flag;
    logic [`PIF_NFLAG-1:0] next_err;

    genvar f;
    for (f = 0; f < `PIF_NFLAG; f++) begin : g_flag
        logic clr;
        assign clr = (op == pif_pkg::pif_cle)
            && (instr_type == `PIF_CLE_ALL // [RULE1]
            || instr_type == 8'(f + 1)); // [RULE2]
        // A new error in the clearing cycle survives
        assign next_err[f] = err_event[f] | (err_flag[f] & ~clr);
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            err_flag <= '0;
        end else if (clk_en) begin
            err_flag <= next_err;
        end
    end

    assign err_flags = err_flag;

    // Interrupt enables and pending sources

    logic global_en;
    logic [NUM_IRQ-1:0] en;
    logic [NUM_IRQ-1:0] next_en;
    logic [NUM_IRQ-1:0] pend;
    logic [NUM_IRQ-1:0] next_pend;
    logic [NUM_IRQ-1:0] ready;
    logic [IDX_W-1:0] take_idx;
    logic take;
    logic inhibit;
    pif_pkg::pif_mode_t mode;

    genvar g;
    for (g = 0; g < NUM_IRQ; g++) begin : g_irq
        logic hit;
        logic taken;
        assign hit = type_ok && (instr_type[IDX_W-1:0] == IDX_W'(g));
        assign taken = take && (take_idx == IDX_W'(g));
        always_comb begin
            next_en[g] = en[g];
            if (op == pif_pkg::pif_ei && hit) begin
                next_en[g] = 1'b1; // [RULE3]
            end else if (op == pif_pkg::pif_di && hit) begin
                next_en[g] = 1'b0; // [RULE5]
            end
        end
        // A source firing while its request is taken stays pending
        assign next_pend[g] = irq_src[g] | (pend[g] & ~taken);
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            en <= '0;
            pend <= '0;
        end else if (clk_en) begin
            en <= next_en;
            pend <= next_pend;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            global_en <= 1'b0;
        end else if (clk_en && instr_type == `PIF_IRQ_GLOBAL) begin
            if (op == pif_pkg::pif_ei) begin
                global_en <= 1'b1; // [RULE4]
            end else if (op == pif_pkg::pif_di) begin
                global_en <= 1'b0; // [RULE6]
            end
        end
    end

    assign ready = pend & en;

    // Lowest number wins when several are ready
    always_comb begin
        take_idx = '0;
        for (int i = NUM_IRQ - 1; i >= 0; i--) begin
            if (ready[i]) begin
                take_idx = IDX_W'(i);
            end
        end
    end

    // Only taken between instructions, and never nested
    assign take = global_en && !in_handler && !inhibit
        && !instr_valid && (|ready); // [RULE14]

    // Handler address table

    pif_vec_if #(.NUM_IRQ(NUM_IRQ), .VEC_W(VEC_W)) vec ();

    assign vec.wr_en = (op == pif_pkg::pif_define_vector_op) && type_ok; // [RULE8]
    assign vec.wr_idx = instr_type[IDX_W-1:0];
    assign vec.wr_addr = instr_value[VEC_W-1:0]; // [RULE8]
    // Lookup is combinational on the winner, so the jump address is
    // captured at the same edge as the context and cannot go stale
    assign vec.rd_idx = take_idx;

    pif_vector_table #(.NUM_IRQ(NUM_IRQ), .VEC_W(VEC_W)) u_table (
        .clock(clock),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .vec(vec)
    );

    // Handler entry and return

    logic return_from_handler_op_hit;

    // Return outside a handler has nothing to restore and is dropped
    assign return_from_handler_op_hit = (op == pif_pkg::pif_return_from_handler_op) && in_handler; // [RULE7] [RULE10]

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            mode <= pif_pkg::pif_run;
        end else if (clk_en) begin
            case (mode)
                pif_pkg::pif_run: begin
                    if (take) begin
                        mode <= pif_pkg::pif_handler; // [RULE14]
                    end
                end
                pif_pkg::pif_handler: begin
                    if (return_from_handler_op_hit) begin
                        mode <= pif_pkg::pif_run; // [RULE10]
                    end
                end
                default: mode <= pif_pkg::pif_run;
            endcase
        end
    end

    assign in_handler = (mode == pif_pkg::pif_handler);

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            restore_accu <= '0;
            restore_x <= '0;
            restore_flags <= '0;
            restore_pc <= '0;
        end else if (clk_en && take) begin
            restore_accu <= cpu_accu; // [RULE14]
            restore_x <= cpu_x;
            restore_flags <= cpu_flags;
            restore_pc <= cpu_pc;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            handler_jump <= 1'b0;
            jump_addr <= '0;
            restore_valid <= 1'b0;
        end else if (clk_en) begin
            handler_jump <= take;
            if (take) begin
                jump_addr <= vec.rd_addr; // [RULE14]
            end
            // Saved context stands on the restore outputs with this pulse
            restore_valid <= return_from_handler_op_hit; // [RULE11]
        end
    end

    // Direct mode reply

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            reply_valid <= 1'b0;
            reply_status <= '0;
            reply_opcode <= '0;
        end else if (clk_en) begin
            reply_valid <= instr_valid && instr_direct;
            if (instr_valid && instr_direct) begin
                reply_status <= sum_ok ? `PIF_ST_OK : `PIF_ST_CHK; // [RULE15]
                reply_opcode <= instr_opcode;
            end
        end
    end

    // Event status, mask and interrupt line

    logic [`PIF_NEV-1:0] stat;
    logic [`PIF_NEV-1:0] next_stat;
    logic [`PIF_NEV-1:0] ev;
    logic [`PIF_NEV-1:0] mask;
    logic stat_rd;

    always_comb begin
        ev = '0;
        ev[`PIF_EV_ENTRY] = take;
        ev[`PIF_EV_RETURN] = return_from_handler_op_hit;
        ev[`PIF_EV_ERROR] = |err_event;
        ev[`PIF_EV_CHK] = instr_valid && instr_direct && !sum_ok;
    end

    assign stat_rd = reg_rd && (reg_addr == `PIF_REG_STAT);

    // Read clears, but an event in the same cycle is kept
    assign next_stat = ev | (stat & ~{`PIF_NEV{stat_rd}});

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            stat <= '0;
        end else if (clk_en) begin
            stat <= next_stat;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            mask <= `PIF_MASK_RST;
            inhibit <= `PIF_CTRL_RST;
        end else if (clk_en && reg_wr) begin
            if (reg_addr == `PIF_REG_MASK) begin
                mask <= reg_wdata[`PIF_NEV-1:0];
            end
            if (reg_addr == `PIF_REG_CTRL) begin
                inhibit <= reg_wdata[0];
            end
        end
    end

    // Level output, drops in the cycle after the status read clears it
    // Limitation: no per-interrupt status, only the four event kinds
    assign irq = |(stat & mask);

    // Register read port, unmapped offsets read zero

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            reg_rdata <= '0;
        end else if (clk_en) begin
            reg_rdata <= '0;
            if (reg_rd) begin
                case (reg_addr)
                    `PIF_REG_STAT: reg_rdata <= 32'(stat);
                    `PIF_REG_MASK: reg_rdata <= 32'(mask);
                    `PIF_REG_ERR: reg_rdata <= 32'(err_flag);
                    `PIF_REG_EN: reg_rdata <= 32'(en);
                    `PIF_REG_PEND: reg_rdata <= 32'(pend);
                    `PIF_REG_CTRL: reg_rdata <= 32'(inhibit);
                    `PIF_REG_STATE: reg_rdata <= {30'h0, global_en, in_handler};
                    default: reg_rdata <= '0;
                endcase
            end
        end
    end

endmodule // pif_core

/* File: pif_core_checker.sv */
// Concurrent checks on the ports of the interrupt and error-flag unit
`timescale 1ns/1ps
`include "pif_map.svh"

module pif_core_checker (
    input logic clock,
    input logic rst_b,
    input logic clk_en,
    input logic instr_valid,
    input logic instr_direct,
    input logic [7:0] instr_target,
    input logic [7:0] instr_opcode,
    input logic [7:0] instr_type,
    input logic [7:0] instr_bank,
    input logic [31:0] instr_value,
    input logic [7:0] instr_checksum,
    input logic reply_valid,
    input logic [7:0] reply_status,
    input logic [7:0] reply_opcode,
    input logic [`PIF_NFLAG-1:0] err_event,
    input logic [`PIF_NFLAG-1:0] err_flags,
    input logic handler_jump,
    input logic restore_valid,
    input logic in_handler
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    logic [7:0] sum;
    logic tk;
    logic ok;
    assign sum = instr_target + instr_opcode + instr_type + instr_bank + instr_value[31:24]
        + instr_value[23:16] + instr_value[15:8] + instr_value[7:0];
    assign tk = instr_valid && clk_en;
    assign ok = !instr_direct || sum == instr_checksum;
    property p_reply;
        tk && instr_direct |=> reply_valid && reply_opcode == $past(instr_opcode);
    endproperty
    a_reply: assert property (p_reply) else $error("direct reply missing");
    property p_noreply;
        clk_en && !(instr_valid && instr_direct) |=> !reply_valid;
    endproperty
    a_noreply: assert property (p_noreply) else $error("reply without command");
    property p_bad;
        tk && instr_direct && sum != instr_checksum |=> reply_status == 8'h01;
    endproperty
    a_bad: assert property (p_bad) else $error("bad checksum not refused");
    property p_good;
        tk && instr_direct && sum == instr_checksum |=> reply_status == 8'h64;
    endproperty
    a_good: assert property (p_good) else $error("status not ok");
    // A clear beside an event loses to it, so such cycles are left out
    property p_clr_all;
        tk && ok && instr_opcode == 8'h24 && instr_type == 8'h00 && err_event == 0
            |=> err_flags == 0;
    endproperty
    a_clr_all: assert property (p_clr_all) else $error("clear all failed");
    property p_clr_one;
        tk && ok && instr_opcode == 8'h24 && instr_type inside {[8'h01:8'h05]}
            && err_event == 0
            |=> err_flags == ($past(err_flags) & ~(5'h01 << ($past(instr_type) - 8'h01)));
    endproperty
    a_clr_one: assert property (p_clr_one) else $error("single clear wrong");
    property p_set;
        clk_en && err_event != 0 |=> (err_flags & $past(err_event)) == $past(err_event);
    endproperty
    a_set: assert property (p_set) else $error("error event lost");
    property p_take;
        $rose(in_handler) |-> handler_jump && !$past(instr_valid);
    endproperty
    a_take: assert property (p_take) else $error("entry without jump");
    property p_ret;
        $fell(in_handler) && $past(rst_b)
            |-> restore_valid && $past(instr_valid) && $past(instr_opcode) == 8'h26;
    endproperty
    a_ret: assert property (p_ret) else $error("handler left without return");
endmodule // pif_core_checker

bind pif_core pif_core_checker pif_core_checker_inst (.clock, .rst_b, .clk_en, .instr_valid,
    .instr_direct, .instr_target, .instr_opcode, .instr_type, .instr_bank, .instr_value,
    .instr_checksum, .reply_valid, .reply_status, .reply_opcode, .err_event, .err_flags,
    .handler_jump, .restore_valid, .in_handler);

/* File: pif_host_model.sv */
// Host or stored program presenting instructions to the unit
`timescale 1ns/1ps

module pif_host_model (
    input logic clock,
    output logic instr_valid,
    output logic instr_direct,
    output logic [7:0] instr_target,
    output logic [7:0] instr_opcode,
    output logic [7:0] instr_type,
    output logic [7:0] instr_bank,
    output logic [31:0] instr_value,
    output logic [7:0] instr_checksum
);
    initial begin
        instr_valid = 1'b0;
        instr_direct = 1'b0;
        instr_target = 8'h01;
        instr_opcode = 8'h00;
        instr_type = 8'h00;
        instr_bank = 8'h00;
        instr_value = 32'h0;
        instr_checksum = 8'h00;
    end
    // Opcode, value and checksum are scrambled once released so stale values cannot pass for live ones
    task automatic send(input logic d, input logic [7:0] op, input logic [7:0] ty,
        input logic [7:0] bk, input logic [31:0] v, input logic bad);
        logic [7:0] s;
        s = 8'h01 + op + ty + bk + v[31:24] + v[23:16] + v[15:8] + v[7:0];
        @(posedge clock);
        instr_valid <= 1'b1;
        instr_direct <= d;
        instr_opcode <= op;
        instr_type <= ty;
        instr_bank <= bk;
        instr_value <= v;
        instr_checksum <= bad ? ~s : s;
        @(posedge clock);
        instr_valid <= 1'b0;
        instr_opcode <= ~op;
        instr_value <= ~v;
        instr_checksum <= ~s;
    endtask
endmodule // pif_host_model

/* File: testbench.sv */
// Self-checking bench for the interrupt and error-flag unit
`timescale 1ns/1ps
`include "pif_map.svh"

module testbench;
    logic clock, rst_b, clk_en, instr_valid, instr_direct;
    logic [7:0] instr_target, instr_opcode, instr_type, instr_bank, instr_checksum;
    logic [31:0] instr_value, cpu_accu, cpu_x, restore_accu, restore_x, reg_wdata, reg_rdata;
    logic reply_valid, handler_jump, restore_valid, in_handler, reg_wr, reg_rd, irq;
    logic [7:0] reply_status, reply_opcode, cpu_flags, restore_flags, reg_addr;
    logic [4:0] err_event, err_flags;
    logic [15:0] irq_src, cpu_pc, jump_addr, restore_pc;
    int n_mismatch = 0;
    int checks_done = 0;

    pif_core pif_core_inst (.clock, .rst_b, .clk_en, .instr_valid, .instr_direct,
        .instr_target, .instr_opcode, .instr_type, .instr_bank, .instr_value, .instr_checksum,
        .reply_valid, .reply_status, .reply_opcode, .err_event, .err_flags, .irq_src,
        .cpu_accu, .cpu_x, .cpu_flags, .cpu_pc, .handler_jump, .jump_addr, .restore_valid,
        .restore_accu, .restore_x, .restore_flags, .restore_pc, .in_handler, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
    pif_host_model pif_host_model_inst (.clock, .instr_valid, .instr_direct, .instr_target,
        .instr_opcode, .instr_type, .instr_bank, .instr_value, .instr_checksum);

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic report_and_stop;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmd(input logic d, input logic [7:0] op, input logic [7:0] ty,
        input logic [7:0] bk, input logic [31:0] v, input logic bad);
        pif_host_model_inst.send(d, op, ty, bk, v, bad);
        #1;
        cmp(reply_valid, d);
        if (d) cmp(reply_status, bad ? 8'h01 : 8'h64);
        if (d) cmp(reply_opcode, op);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        cmp(reg_rdata, exp);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    task automatic pulse_ev;
        @(posedge clock);
        err_event <= 5'h1f;
        @(posedge clock);
        err_event <= 5'h00;
    endtask

    // Pulses one source, then watches a fixed span for the handler entry
    task automatic fire(input int n, input logic exp);
        logic seen;
        seen = 1'b0;
        @(posedge clock);
        irq_src <= 16'h0001 << n;
        @(posedge clock);
        irq_src <= 16'h0000;
        repeat (6) begin
            @(posedge clock);
            #1;
            if (handler_jump === 1'b1) seen = 1'b1;
        end
        cmp(seen, exp);
    endtask

    initial begin
        repeat (3000) @(posedge clock);
        n_mismatch++;
        report_and_stop;
    end

    initial begin
        {rst_b, reg_wr, reg_rd, reg_addr, reg_wdata, err_event, irq_src} = '0;
        {cpu_accu, cpu_x, cpu_flags, cpu_pc} = '0;
        clk_en = 1'b1;
        repeat (5) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        #1;
        cmp({err_flags, irq, in_handler, jump_addr}, 32'h0);
        rd(`PIF_REG_STAT, 32'h0);
        for (int i = 1; i <= 5; i++) begin
            pulse_ev;
            cmd(1'b1, `PIF_OP_CLE, i[7:0], 8'h00, 32'h0, 1'b0);
            cmp(err_flags, 5'h1f & ~(5'h01 << (i - 1)));
        end
        pulse_ev;
        cmd(1'b1, `PIF_OP_CLE, 8'h00, 8'h00, 32'h0, 1'b1);
        cmp(err_flags, 5'h1f);
        cmd(1'b0, `PIF_OP_CLE, 8'h00, 8'h33, 32'h5, 1'b0);
        cmp(err_flags, 5'h00);
        rd(`PIF_REG_STAT, 32'hc);
        rd(`PIF_REG_STAT, 32'h0);
        cmd(1'b0, `PIF_OP_DEFINE_VECTOR_OP, 8'h03, 8'h00, 32'h50, 1'b0);
        cmd(1'b0, `PIF_OP_DEFINE_VECTOR_OP, 8'h03, 8'h00, 32'h77, 1'b0);
        cmd(1'b1, `PIF_OP_EI, 8'h03, 8'h5a, 32'hdeadbeef, 1'b0);
        cmd(1'b1, `PIF_OP_EI, 8'hff, 8'h00, 32'h0, 1'b0);
        wr(`PIF_REG_MASK, 32'h3);
        wr(8'h40, 32'hffffffff);
        rd(8'h40, 32'h0);
        rd(`PIF_REG_MASK, 32'h3);
        cpu_accu <= 32'h12345678;
        cpu_x <= 32'h9abcdef0;
        cpu_flags <= 8'ha5;
        cpu_pc <= 16'h0123;
        fire(3, 1'b1);
        cmp(jump_addr, 16'h0077);
        cmp({in_handler, irq}, 2'b11);
        {cpu_accu, cpu_x, cpu_flags, cpu_pc} <= '0;
        rd(`PIF_REG_STAT, 32'h1);
        cmp(irq, 1'b0);
        cmd(1'b0, `PIF_OP_RETURN_FROM_HANDLER_OP, 8'hff, 8'h44, 32'h1, 1'b0);
        cmp({restore_valid, in_handler}, 2'b10);
        cmp({restore_flags, restore_pc}, 24'ha50123);
        cmp(restore_accu, 32'h12345678);
        cmp(restore_x, 32'h9abcdef0);
        cmd(1'b0, `PIF_OP_RETURN_FROM_HANDLER_OP, 8'hff, 8'h00, 32'h0, 1'b0);
        cmp(restore_valid, 1'b0);
        cmd(1'b1, `PIF_OP_DI, 8'hff, 8'h00, 32'h0, 1'b0);
        fire(3, 1'b0);
        cmd(1'b1, `PIF_OP_DI, 8'h03, 8'h11, 32'h9, 1'b0);
        cmd(1'b1, `PIF_OP_EI, 8'hff, 8'h00, 32'h0, 1'b0);
        fire(3, 1'b0);
        cmd(1'b1, `PIF_OP_EI, 8'h03, 8'h00, 32'h0, 1'b0);
        repeat (4) @(posedge clock);
        #1;
        cmp(in_handler, 1'b1);
        rd(`PIF_REG_STATE, 32'h3);
        cmd(1'b0, `PIF_OP_RETURN_FROM_HANDLER_OP, 8'hff, 8'h00, 32'h0, 1'b0);
        rd(`PIF_REG_STATE, 32'h2);
        // Clock enable low must freeze the flags against a burst of errors
        clk_en <= 1'b0;
        pulse_ev;
        @(posedge clock);
        #1;
        cmp(err_flags, 32'h0);
        clk_en <= 1'b1;
        pulse_ev;
        @(posedge clock);
        #1;
        cmp(err_flags, 32'h1f);
        report_and_stop;
    end
endmodule // testbench
